// ---- design/dma_write_pkg.sv ----
// Operation
// - quiet completion: enter, clear issue, signature, power
// - setup frame: enter, flag, status, interrupt, activate
// - fetch command, then transmit it
// - disk prefetch: descriptors, data, then wait
// - packet prefetch: bytes, descriptors, data, wait
// - pio setup, then send packet bytes
// - activate: accept, then send one data frame
// - repeat activate and send until count met
// - accept register frame, branch on interrupt bit
// - last command and enabled: request low power
// - irq completion: enter, clear, flag, status, interrupt, signature
package dma_write_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned COUNT_W    = 24;
  localparam int unsigned SIG_W      = 32;
  localparam int unsigned FIS_WORDS  = 2048;
  localparam int unsigned FRAME_W    = 12;
  localparam logic [COUNT_W-1:0] CNT_ZERO = 24'h00_0000;
  localparam logic [COUNT_W-1:0] CNT_ONE  = 24'h00_0001;
  localparam logic [SIG_W-1:0]   SIG_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    FIS_DMA_ACTIVATE,
    FIS_PIO_SETUP,
    FIS_D2H_REG,
    FIS_DMA_SETUP
  } fis_kind_t;

  typedef enum logic [2:0] {
    STEP_NONE,
    STEP_FETCH,
    STEP_TRANSMIT,
    STEP_PF_PACKET,
    STEP_PF_DESC,
    STEP_PF_DATA,
    STEP_PACKET_SEND
  } step_t;

  typedef struct packed {
    logic                 region_descriptor;
    logic                 packet;
    logic                 queued;
    logic                 write;
    logic                 prefetch;
    logic [COUNT_W-1:0]   word_count;
  } cmd_t;

  typedef struct packed {
    fis_kind_t            kind;
    logic                 irq_bit;
    logic [SIG_W-1:0]     signature;
  } rx_fis_t;

  typedef enum logic [4:0] {
    ST_IDLE, ST_FETCH, ST_TRANSMIT, ST_PF_PACKET, ST_PF_DESC, ST_PF_DATA,
    ST_WAIT, ST_ACCEPT, ST_PROGRAMMED_IO_ENTRY, ST_PKT_ENTRY, ST_PROGRAMMED_IO_UPDATE, ST_SEND,
    ST_REG_ENTRY, ST_CLEAR_ISSUE, ST_SET_INTR, ST_SET_STATUS, ST_GEN_INTR,
    ST_SIG_UPDATE, ST_AGGRESSIVE_LOW_POWER_STEP, ST_DS_ENTRY, ST_DS_SET_INTR, ST_DS_SET_STATUS,
    ST_DS_GEN_INTR, ST_DS_AUTO
  } seq_state_t;
endpackage : dma_write_pkg

// ---- design/pair_buffer.sv ----
module pair_buffer #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data,
  // flush between commands
  input  wire logic             flush
);
  logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
  logic [1:0]       fill_q, fill_d;
  logic             push, pop;

  assign in_ready  = (fill_q != 2'h2);
  assign out_valid = (fill_q != 2'h0);
  assign out_data  = head_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    fill_d = fill_q;
    if (flush) begin
      fill_d = 2'h0;
    end else begin
      // head always holds the oldest word
      if (pop) begin
        head_d = (fill_q == 2'h2) ? tail_q : in_data;
      end else if (push && fill_q == 2'h0) begin
        head_d = in_data;
      end
      if (push && (fill_q == 2'h2 || (fill_q == 2'h1 && !pop))) begin
        tail_d = in_data;
      end
      fill_d = fill_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      head_q <= '0;
      tail_q <= '0;
      fill_q <= 2'h0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      fill_q <= fill_d;
    end
  end
endmodule : pair_buffer

// ---- design/dma_write_seq.sv ----
module dma_write_seq
  import dma_write_pkg::*;
#(
  parameter int unsigned MAX_FIS_WORDS = dma_write_pkg::FIS_WORDS
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset,
  // command issue
  input  wire logic                              cmd_valid,
  output      logic                              cmd_ready,
  input  wire dma_write_pkg::cmd_t               cmd,
  output      logic                              issue_clear,
  // configuration
  input  wire logic                              last_cmd,
  input  wire logic                              aggr_pm_en,
  input  wire logic                              slumber_sel,
  // outside steps
  output      dma_write_pkg::step_t              step_req,
  input  wire logic                              step_ack,
  // received frames
  input  wire logic                              rx_valid,
  output      logic                              rx_ready,
  input  wire dma_write_pkg::rx_fis_t            rx_fis,
  // memory read data
  input  wire logic                              mem_valid,
  output      logic                              mem_ready,
  input  wire logic [dma_write_pkg::DATA_W-1:0]  mem_data,
  // link transmit data
  output      logic                              tx_valid,
  input  wire logic                              tx_ready,
  output      logic [dma_write_pkg::DATA_W-1:0]  tx_data,
  output      logic                              tx_last,
  // status and interrupt
  input  wire logic                              status_clear,
  output      logic                              intr_cond_q,
  output      logic                              irq_status_q,
  output      logic                              irq_pulse,
  output      logic [dma_write_pkg::SIG_W-1:0]   signature_q,
  output      logic                              auto_activation,
  output      logic                              pm_partial_req,
  output      logic                              pm_slumber_req,
  output      logic                              busy
);
  import dma_write_pkg::*;

  localparam logic [COUNT_W-1:0] FIS_MAX = COUNT_W'(MAX_FIS_WORDS);

  seq_state_t         state_q, state_d;
  cmd_t               cmd_q, cmd_d;
  rx_fis_t            fis_q, fis_d;
  logic [COUNT_W-1:0] remain_q, remain_d;
  logic [COUNT_W-1:0] pull_q, pull_d;
  logic [COUNT_W-1:0] frame_q, frame_d;
  logic               pkt_done_q, pkt_done_d;
  logic               intr_d, status_d;
  logic [SIG_W-1:0]   sig_d;
  logic               buf_in_ready, buf_out_valid;

  // data words pass a two-entry buffer so a link stall loses nothing
  pair_buffer #(.WIDTH(DATA_W)) data_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (mem_valid && mem_ready),
    .in_ready  (buf_in_ready),
    .in_data   (mem_data),
    .out_valid (buf_out_valid),
    .out_ready (tx_ready && state_q == ST_SEND),
    .out_data  (tx_data),
    .flush     (state_q == ST_IDLE)
  );

  assign cmd_ready = (state_q == ST_IDLE);
  assign rx_ready  = (state_q == ST_WAIT);
  assign busy      = (state_q != ST_IDLE);
  assign mem_ready = (state_q == ST_SEND) && buf_in_ready && (pull_q != CNT_ZERO);
  assign tx_valid  = (state_q == ST_SEND) && buf_out_valid;
  assign tx_last   = (frame_q == CNT_ONE);

  always_comb begin
    step_req = STEP_NONE;
    case (state_q)
      ST_FETCH:      step_req = STEP_FETCH;
      ST_TRANSMIT:   step_req = STEP_TRANSMIT;
      ST_PF_PACKET:  step_req = STEP_PF_PACKET;
      ST_PF_DESC:    step_req = STEP_PF_DESC;
      ST_PF_DATA:    step_req = STEP_PF_DATA;
      ST_PROGRAMMED_IO_UPDATE: step_req = STEP_PACKET_SEND;
      default:       step_req = STEP_NONE;
    endcase
  end

  assign issue_clear     = (state_q == ST_CLEAR_ISSUE);
  assign irq_pulse       = (state_q == ST_GEN_INTR) || (state_q == ST_DS_GEN_INTR);
  assign auto_activation = (state_q == ST_DS_AUTO);
  assign pm_partial_req  = (state_q == ST_AGGRESSIVE_LOW_POWER_STEP) && last_cmd && aggr_pm_en && !slumber_sel;
  assign pm_slumber_req  = (state_q == ST_AGGRESSIVE_LOW_POWER_STEP) && last_cmd && aggr_pm_en && slumber_sel;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d    = state_q;
    cmd_d      = cmd_q;
    fis_d      = fis_q;
    remain_d   = remain_q;
    pull_d     = pull_q;
    frame_d    = frame_q;
    pkt_done_d = pkt_done_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          cmd_d      = cmd;
          remain_d   = cmd.word_count;
          pkt_done_d = 1'b0;
          state_d    = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (step_ack) begin
          state_d = ST_TRANSMIT;
        end
      end
      ST_TRANSMIT: begin
        if (step_ack) begin
          if (!cmd_q.prefetch) begin
            state_d = ST_WAIT;
          end else if (cmd_q.packet) begin
            state_d = ST_PF_PACKET;
          end else begin
            state_d = ST_PF_DESC;
          end
        end
      end
      ST_PF_PACKET: begin
        if (step_ack) begin
          state_d = ST_PF_DESC;
        end
      end
      ST_PF_DESC: begin
        if (step_ack) begin
          state_d = ST_PF_DATA;
        end
      end
      ST_PF_DATA: begin
        if (step_ack) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (rx_valid) begin
          fis_d   = rx_fis;
          state_d = ST_ACCEPT;
        end
      end
      ST_ACCEPT: begin
        case (fis_q.kind)
          FIS_PIO_SETUP: begin
            state_d = (cmd_q.packet && !pkt_done_q) ? ST_PROGRAMMED_IO_ENTRY : ST_WAIT;
          end
          FIS_DMA_ACTIVATE: begin
            pull_d  = (remain_q > FIS_MAX) ? FIS_MAX : remain_q;
            frame_d = (remain_q > FIS_MAX) ? FIS_MAX : remain_q;
            state_d = (remain_q == CNT_ZERO) ? ST_WAIT : ST_SEND;
          end
          FIS_D2H_REG:   state_d = ST_REG_ENTRY;
          default:       state_d = ST_DS_ENTRY;
        endcase
      end
      ST_PROGRAMMED_IO_ENTRY:  state_d = ST_PKT_ENTRY;
      ST_PKT_ENTRY:  state_d = ST_PROGRAMMED_IO_UPDATE;
      ST_PROGRAMMED_IO_UPDATE: begin
        if (step_ack) begin
          pkt_done_d = 1'b1;
          state_d    = ST_WAIT;
        end
      end
      ST_SEND: begin
        if (mem_ready && mem_valid) begin
          pull_d = pull_q - CNT_ONE;
        end
        if (tx_valid && tx_ready) begin
          frame_d  = frame_q - CNT_ONE;
          remain_d = remain_q - CNT_ONE;
          if (frame_q == CNT_ONE) begin
            state_d = ST_WAIT;
          end
        end
      end
      ST_REG_ENTRY:   state_d = ST_CLEAR_ISSUE;
      ST_CLEAR_ISSUE: state_d = fis_q.irq_bit ? ST_SET_INTR : ST_SIG_UPDATE;
      ST_SET_INTR:    state_d = ST_SET_STATUS;
      ST_SET_STATUS:  state_d = ST_GEN_INTR;
      ST_GEN_INTR:    state_d = ST_SIG_UPDATE;
      ST_SIG_UPDATE:  state_d = ST_AGGRESSIVE_LOW_POWER_STEP;
      ST_AGGRESSIVE_LOW_POWER_STEP:     state_d = ST_IDLE;
      ST_DS_ENTRY:      state_d = ST_DS_SET_INTR;
      ST_DS_SET_INTR:   state_d = ST_DS_SET_STATUS;
      ST_DS_SET_STATUS: state_d = ST_DS_GEN_INTR;
      ST_DS_GEN_INTR:   state_d = ST_DS_AUTO;
      ST_DS_AUTO:       state_d = ST_WAIT;
      default:          state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= ST_IDLE;
      cmd_q      <= '0;
      fis_q      <= '0;
      remain_q   <= CNT_ZERO;
      pull_q     <= CNT_ZERO;
      frame_q    <= CNT_ZERO;
      pkt_done_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cmd_q      <= cmd_d;
      fis_q      <= fis_d;
      remain_q   <= remain_d;
      pull_q     <= pull_d;
      frame_q    <= frame_d;
      pkt_done_q <= pkt_done_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky interrupt flags and signature; set wins over clear
  always_comb begin
    intr_d   = intr_cond_q;
    status_d = irq_status_q;
    sig_d    = signature_q;
    if (status_clear) begin
      intr_d   = 1'b0;
      status_d = 1'b0;
    end
    if (state_q == ST_SET_INTR || state_q == ST_DS_SET_INTR) begin
      intr_d = 1'b1;
    end
    if (state_q == ST_SET_STATUS || state_q == ST_DS_SET_STATUS) begin
      status_d = 1'b1;
    end
    if (state_q == ST_SIG_UPDATE) begin
      sig_d = fis_q.signature;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      intr_cond_q  <= 1'b0;
      irq_status_q <= 1'b0;
      signature_q  <= SIG_RST;
    end else begin
      intr_cond_q  <= intr_d;
      irq_status_q <= status_d;
      signature_q  <= sig_d;
    end
  end
endmodule : dma_write_seq

// ---- bench/dma_write_seq_properties.sv ----
module dma_write_seq_properties
  import dma_write_pkg::*;
#(
  parameter int unsigned MAX_FIS_WORDS = dma_write_pkg::FIS_WORDS
) (
  // clock and reset
  input wire logic                             clk,
  input wire logic                             reset,
  // watched ports
  input wire logic                             cmd_valid,
  input wire logic                             cmd_ready,
  input wire logic                             busy,
  input wire dma_write_pkg::step_t             step_req,
  input wire logic                             step_ack,
  input wire logic                             rx_valid,
  input wire logic                             rx_ready,
  input wire dma_write_pkg::rx_fis_t           rx_fis,
  input wire logic                             tx_valid,
  input wire logic                             tx_ready,
  input wire logic [dma_write_pkg::DATA_W-1:0] tx_data,
  input wire logic                             tx_last,
  input wire logic                             issue_clear,
  input wire logic                             intr_cond_q,
  input wire logic                             irq_status_q,
  input wire logic                             irq_pulse,
  input wire logic [dma_write_pkg::SIG_W-1:0]  signature_q,
  input wire logic                             auto_activation,
  input wire logic                             pm_partial_req,
  input wire logic                             pm_slumber_req,
  input wire logic                             last_cmd,
  input wire logic                             aggr_pm_en,
  input wire logic                             slumber_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned      wcnt_q;
  int unsigned      wcnt_d;
  logic [SIG_W-1:0] sig_q;
  logic [SIG_W-1:0] sig_d;

  always_comb begin
    wcnt_d = wcnt_q;
    sig_d  = sig_q;
    if (tx_valid && tx_ready) wcnt_d = tx_last ? 0 : wcnt_q + 1;
    if (rx_valid && rx_ready) sig_d = rx_fis.signature;
  end

  always_ff @(posedge clk) begin
    wcnt_q <= reset ? 0 : wcnt_d;
    sig_q  <= reset ? SIG_RST : sig_d;
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_cmd_fetch: assert property (cmd_valid && cmd_ready |=> step_req == STEP_FETCH)
    else $error("no fetch step after command");
  a_fetch_send: assert property (step_req == STEP_FETCH && step_ack |=>
    step_req == STEP_TRANSMIT) else $error("transmit does not follow fetch");
  a_desc_data: assert property (step_req == STEP_PF_DESC && step_ack |=>
    step_req == STEP_PF_DATA) else $error("data prefetch does not follow descriptors");
  a_pkt_desc: assert property (step_req == STEP_PF_PACKET && step_ack |=>
    step_req == STEP_PF_DESC) else $error("descriptor prefetch does not follow packet");
  a_busy_refuse: assert property (cmd_valid && cmd_ready |=> busy && !cmd_ready)
    else $error("command accepted while busy");
  a_frame_len: assert property (tx_valid && tx_ready |-> wcnt_q < MAX_FIS_WORDS)
    else $error("data frame too long");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("tx word dropped");
  a_irq_flags: assert property (irq_pulse |-> intr_cond_q && irq_status_q)
    else $error("interrupt before flags set");
  a_auto_order: assert property (auto_activation |-> $past(irq_pulse))
    else $error("activation not right after interrupt");
  a_sig_after: assert property (issue_clear |-> ##[1:6] signature_q == sig_q)
    else $error("signature not updated");
  a_pm_cause: assert property (pm_partial_req || pm_slumber_req |-> last_cmd &&
    aggr_pm_en && pm_slumber_req == slumber_sel && pm_partial_req != pm_slumber_req)
    else $error("bad power request");

  c_packet: cover property (step_req == STEP_PACKET_SEND && step_ack);
  c_slumber: cover property (pm_slumber_req);
  c_auto: cover property (auto_activation);
endmodule : dma_write_seq_properties

// ---- bench/drive_model.sv ----
module drive_model
  import dma_write_pkg::*;
(
  // clock and stall control
  input  wire logic                             clk,
  input  wire logic                             slow,
  // frames to host
  output      logic                             rx_valid,
  input  wire logic                             rx_ready,
  output      dma_write_pkg::rx_fis_t           rx_fis,
  // data from host
  input  wire logic                             tx_valid,
  output      logic                             tx_ready,
  input  wire logic [dma_write_pkg::DATA_W-1:0] tx_data,
  input  wire logic                             tx_last,
  // tallies
  output      int                               errs,
  output      int                               cmps
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] exp_q;

  initial begin
    rx_valid = 1'b0;
    rx_fis   = '0;
    errs     = 0;
    cmps     = 0;
    exp_q    = '0;
  end

  // stall pattern is unknown until the first falling edge, then starts high
  always @(negedge clk) tx_ready <= slow ? (tx_ready !== 1'b1) : 1'b1;

  task automatic send_frame(input fis_kind_t k, input logic irq, input logic [SIG_W-1:0] sig,
                            input int unsigned words);
    int unsigned t;
    int unsigned w;
    w = 0;
    @(negedge clk);
    rx_fis   = '{kind: k, irq_bit: irq, signature: sig};
    rx_valid = 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge clk);
      if (rx_ready) break;
    end
    if (t == 100) begin
      errs++;
      $display("[FAIL] rx_ready expected 1 seen timeout");
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_fis   = ~rx_fis;
    for (t = 0; t < 500 && w < words; t++) begin
      @(posedge clk);
      if (tx_valid && tx_ready) begin
        cmps++;
        if (tx_data !== exp_q || tx_last !== (w == words - 1)) begin
          errs++;
          $display("[FAIL] tx word expected %h seen %h last %b", exp_q, tx_data, tx_last);
        end
        exp_q++;
        w++;
      end
    end
    if (w != words) begin
      errs++;
      $display("[FAIL] frame words expected %0d seen %0d", words, w);
    end
  endtask : send_frame
endmodule : drive_model

// ---- bench/sata_host_dma_write_sequencer_tb_top.sv ----
module sata_host_dma_write_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_write_pkg::*;
  logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, step_ack = 1'b0, status_clear = 1'b0;
  logic slow = 1'b1, last_cmd = 1'b1, aggr_pm_en = 1'b1, slumber_sel = 1'b1;
  logic mem_valid = 1'b0, mem_hs = 1'b0;
  logic [DATA_W-1:0] mem_data = '0, tx_data;
  cmd_t cmd = '0;
  logic cmd_ready, issue_clear, rx_valid, rx_ready, mem_ready, tx_valid, tx_ready, tx_last;
  logic intr_cond_q, irq_status_q, irq_pulse, auto_activation, pm_partial_req;
  logic pm_slumber_req, busy;
  logic [SIG_W-1:0] signature_q;
  step_t step_req;
  rx_fis_t rx_fis;
  int err_count = 0, n_compared = 0, derr, dcmp;
  int n_clr = 0, n_irq = 0, n_auto = 0, n_part = 0, n_slum = 0;

  dma_write_seq #(.MAX_FIS_WORDS(4)) dut (.*);
  drive_model u_drive (.*, .errs(derr), .cmps(dcmp));

  initial forever #5 clk = ~clk;

  always @(posedge clk) begin
    mem_hs <= mem_valid && mem_ready;
    n_clr  <= n_clr + int'(issue_clear);
    n_irq  <= n_irq + int'(irq_pulse);
    n_auto <= n_auto + int'(auto_activation);
    n_part <= n_part + int'(pm_partial_req);
    n_slum <= n_slum + int'(pm_slumber_req);
  end

  always @(negedge clk) begin
    mem_valid <= !(slow && mem_hs);
    if (mem_hs) mem_data <= mem_data + 1;
  end

  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    err_count += derr;
    n_compared += dcmp;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tmo(input int t, input int lim);
    if (t >= lim) begin
      err_count++;
      $display("[FAIL] wait expected done seen timeout");
      report_and_stop();
    end
  endtask : tmo

  task automatic issue(input cmd_t c);
    int t;
    @(negedge clk);
    cmd = c;
    cmd_valid = 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (cmd_ready) break;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd = ~c;
    tmo(t, 50);
  endtask : issue

  task automatic steps(input step_t q[$]);
    int t;
    foreach (q[i]) begin
      for (t = 0; t < 50 && step_req === STEP_NONE; t++) @(negedge clk);
      tmo(t, 50);
      chk("step_req", q[i], step_req);
      chk("cmd_ready", 0, cmd_ready);
      step_ack = 1'b1;
      @(negedge clk);
      step_ack = 1'b0;
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
    chk("step_req idle", STEP_NONE, step_req);
  endtask : steps

  task automatic wait_for(input logic idle);
    int t;
    for (t = 0; t < 100; t++) begin
      @(negedge clk);
      if (idle ? !busy : rx_ready) break;
    end
    tmo(t, 100);
  endtask : wait_for

  task automatic tally(input int c, i, a, p, s);
    chk("issue_clear count", c, n_clr);
    chk("irq_pulse count", i, n_irq);
    chk("auto_activation count", a, n_auto);
    chk("pm_partial_req count", p, n_part);
    chk("pm_slumber_req count", s, n_slum);
  endtask : tally

  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    issue('{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 24'h00_0006});
    steps('{STEP_FETCH, STEP_TRANSMIT, STEP_PF_DESC, STEP_PF_DATA});
    u_drive.send_frame(FIS_DMA_ACTIVATE, 1'b0, 32'hFFFF_FFFF, 4);
    u_drive.send_frame(FIS_DMA_ACTIVATE, 1'b0, 32'hFFFF_FFFF, 2);
    u_drive.send_frame(FIS_D2H_REG, 1'b0, 32'h1234_5678, 0);
    wait_for(1'b1);
    chk("signature_q", 32'h1234_5678, signature_q);
    chk("intr_cond_q", 0, intr_cond_q);
    tally(1, 0, 0, 0, 1);
    slow = 1'b0;
    slumber_sel = 1'b0;
    issue('{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 24'h00_0003});
    steps('{STEP_FETCH, STEP_TRANSMIT, STEP_PF_PACKET, STEP_PF_DESC, STEP_PF_DATA});
    u_drive.send_frame(FIS_PIO_SETUP, 1'b0, 32'hFFFF_FFFF, 0);
    steps('{STEP_PACKET_SEND});
    u_drive.send_frame(FIS_DMA_ACTIVATE, 1'b0, 32'hFFFF_FFFF, 3);
    u_drive.send_frame(FIS_D2H_REG, 1'b1, 32'h0BAD_F00D, 0);
    wait_for(1'b1);
    chk("signature_q", 32'h0BAD_F00D, signature_q);
    chk("irq_status_q", 1, irq_status_q);
    tally(2, 1, 0, 1, 1);
    status_clear = 1'b1;
    @(negedge clk);
    status_clear = 1'b0;
    chk("irq_status_q", 0, irq_status_q);
    aggr_pm_en = 1'b0;
    slow = 1'b1;
    issue('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 24'h00_0004});
    steps('{STEP_FETCH, STEP_TRANSMIT});
    u_drive.send_frame(FIS_DMA_SETUP, 1'b0, 32'hFFFF_FFFF, 0);
    wait_for(1'b0);
    chk("intr_cond_q", 1, intr_cond_q);
    tally(2, 2, 1, 1, 1);
    u_drive.send_frame(FIS_DMA_ACTIVATE, 1'b0, 32'hFFFF_FFFF, 4);
    u_drive.send_frame(FIS_D2H_REG, 1'b0, 32'h0000_0001, 0);
    wait_for(1'b1);
    tally(3, 2, 1, 1, 1);
    report_and_stop();
  end
endmodule : sata_host_dma_write_sequencer_tb_top

bind dma_write_seq dma_write_seq_properties #(.MAX_FIS_WORDS(MAX_FIS_WORDS)) u_props (.*);
